/* rtl/stf_tx_frame.sv */
/*
  Transmit frame control: decides per frame cycle whether a data word, a
  control word or a fill frame goes to the serializer, drives the
  ready-for-data handshake, the flag bit and the serial clock selection.
  Assumes inputs synchronous to pclk, an APB master on the register bus,
  and a serializer that takes one frame per cycle when frame_ready is high.
*/
// Overview of operation
// - Ready-for-data toward the user is gated by the link enable input.
// - External clock select makes the parallel clock the serial clock.
// - Fill frame whenever no control or data word, or link disabled.
// - Fill select low gives zero fill frame, high gives a one-type fill.
// - One-type fill variant a or b chosen by running line DC balance.
// - Flag mode high sends the flag input as an extra transparent bit.
// - Flag mode low ignores flag input and toggles flag each data frame.
// - Clock monitor reproduces the divided clock actually used to serialize.
// - Clock monitor outputs power down when monitor power is off.
// - User asserts data available only while ready; word becomes data frame.
// - Ready-for-data is link enable retimed into the frame clock, held low while the buffer is full.
`timescale 1ns/10ps
`default_nettype none

module stf_tx_frame
  import stf_pkg::*;
#(
  parameter int DATA_WIDTH = STF_DATA_WIDTH,
  parameter int FIFO_DEPTH = 16
) (
  // Clock and reset.
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  // APB slave.
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [7:0]            paddr,
  input  wire logic [31:0]           pwdata,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  // User parallel data side.
  input  wire logic [DATA_WIDTH-1:0] data_in,
  input  wire logic                  flag_in,
  input  wire logic                  data_available_n,
  input  wire logic                  control_available,
  output logic                       ready_for_data_out,
  // Receiver startup state machine.
  input  wire logic                  link_enable_in,
  // Clock sources.
  input  wire logic                  vco_clock_in,
  input  wire logic                  parallel_clock_in,
  // Serializer side.
  input  wire logic                  frame_ready,
  output stf_frame_t                 frame_kind_out,
  output logic      [DATA_WIDTH-1:0] frame_word_out,
  output logic                       frame_flag_out,
  output logic                       serial_clock_external,
  // Clock monitor pins.
  output logic                       monitor_out,
  output logic                       monitor_out_n,
  output logic                       monitor_powered
);

  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  localparam int FW = DATA_WIDTH + 1;
  localparam int LW = $clog2(FIFO_DEPTH) + 1;

  logic [STF_CTRL_WIDTH-1:0]       ctrl_reg;
  logic [STF_CTRL_WIDTH-1:0]       ctrl_next;
  logic [31:0]                     prdata_reg;
  logic [31:0]                     count_reg;
  logic signed [STF_DISP_WIDTH-1:0] disp_reg;
  logic signed [STF_DISP_WIDTH-1:0] disp_next;
  logic                            enable_reg;
  logic                            toggle_reg;
  stf_frame_t                      kind_reg;
  stf_frame_t                      kind_next;
  logic [DATA_WIDTH-1:0]           word_reg;
  logic [DATA_WIDTH-1:0]           word_next;
  logic                            flag_reg;
  logic                            flag_next;

  logic                            fill_sel;
  logic                            flag_mode;
  logic                            apb_setup;
  logic                            apb_write;
  logic                            addr_hit;
  logic [31:0]                     read_mux;
  logic                            fifo_in_valid;
  logic                            fifo_in_ready;
  logic [FW-1:0]                   fifo_in_data;
  logic                            fifo_out_valid;
  logic                            fifo_pop;
  logic [FW-1:0]                   fifo_out_data;
  logic [LW-1:0]                   fifo_level;
  logic                            take_word;
  logic                            word_is_ctrl;
  logic                            sent_flag;

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------

  // Signed imbalance of a word: ones minus zeros.
  function automatic logic signed [STF_DISP_WIDTH-1:0] word_balance(
    input logic [DATA_WIDTH-1:0] w
  );
    logic signed [STF_DISP_WIDTH-1:0] acc;
    acc = '0;
    for (int i = 0; i < DATA_WIDTH; i++) begin
      acc = w[i] ? acc + 8'sd1 : acc - 8'sd1;
    end
    return acc;
  endfunction

  // ---------------------------------------------------------------
  // APB register file
  // ---------------------------------------------------------------

  // Every access completes in its first access cycle; unmapped reads give
  // zero and raise pslverr.
  assign fill_sel  = ctrl_reg[STF_CTRL_FILL_BIT];
  assign flag_mode = ctrl_reg[STF_CTRL_FLAG_BIT];
  assign apb_setup = psel & ~penable;
  assign apb_write = psel & penable & pwrite;
  assign addr_hit  = (paddr == STF_CTRL_OFF) | (paddr == STF_STATUS_OFF) |
                     (paddr == STF_DISP_OFF) | (paddr == STF_COUNT_OFF);
  assign pready    = 1'b1;
  assign pslverr   = psel & penable & ~addr_hit;
  assign prdata    = prdata_reg;

  // Read selection; the status word shows the live block state.
  assign read_mux =
    (paddr == STF_CTRL_OFF)   ? {28'h0000000, ctrl_reg} :
    (paddr == STF_STATUS_OFF) ? {{(32-STF_STAT_LEVEL_LSB-LW){1'b0}}, fifo_level,
                                 4'h0, serial_clock_external, toggle_reg,
                                 enable_reg, ready_for_data_out} :
    (paddr == STF_DISP_OFF)   ? {{(32-STF_DISP_WIDTH){disp_reg[STF_DISP_WIDTH-1]}},
                                 disp_reg} :
    (paddr == STF_COUNT_OFF)  ? count_reg : 32'h00000000;

  assign ctrl_next = (apb_write && paddr == STF_CTRL_OFF) ?
                     pwdata[STF_CTRL_WIDTH-1:0] : ctrl_reg;

  // Control register, written in the access cycle, and read data, captured in the setup cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg   <= STF_CTRL_RESET;
      prdata_reg <= 32'h00000000;
    end else begin
      ctrl_reg <= ctrl_next;
      if (apb_setup) prdata_reg <= read_mux;
    end
  end

  // ---------------------------------------------------------------
  // Ready-for-data handshake and input buffering
  // ---------------------------------------------------------------

  // The enable is retimed once so the user sees it in frame timing.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) enable_reg <= 1'b0;
    else          enable_reg <= link_enable_in;
  end

  // Ready also falls when the buffer is full, so the user is stalled
  // instead of losing a word when the serializer holds off.
  assign ready_for_data_out = enable_reg & fifo_in_ready;

  // A word is taken only while ready is shown; a control word wins
  // over data when both are offered in one cycle.
  assign word_is_ctrl  = control_available;
  assign fifo_in_valid = ready_for_data_out &
                         (control_available | ~data_available_n);
  assign fifo_in_data  = word_is_ctrl ?
                         {1'b1, data_in & STF_CTRL_MASK[DATA_WIDTH-1:0]} :
                         {1'b0, data_in};

  // The flag bit is carried beside the word; control words carry zero.
  stf_fifo #(
    .WIDTH (FW + 1),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .pclk      (pclk),
    .presetn   (presetn),
    .in_valid  (fifo_in_valid),
    .in_ready  (fifo_in_ready),
    .in_data   ({fifo_in_data, flag_in & ~word_is_ctrl}),
    .out_ready (fifo_pop),
    .out_valid (fifo_out_valid),
    .out_data  ({fifo_out_data, sent_flag}),
    .level     (fifo_level)
  );

  // ---------------------------------------------------------------
  // Frame selection
  // ---------------------------------------------------------------

  // One decision per cycle while the serializer accepts a frame.
  assign take_word = frame_ready & enable_reg & fifo_out_valid;
  assign fifo_pop  = take_word;

  // Choose the next frame and work out its effect on the line balance.
  always_comb begin
    kind_next = kind_reg;
    word_next = word_reg;
    flag_next = flag_reg;
    if (frame_ready) begin
      if (take_word) begin
        kind_next = fifo_out_data[FW-1] ? STF_CONTROL_K : STF_DATA_K;
        word_next = fifo_out_data[DATA_WIDTH-1:0];
        flag_next = flag_mode ? sent_flag : toggle_reg;
      end else if (!fill_sel) begin
        kind_next = STF_FILL_ZERO_K;
        word_next = STF_FILL_ZERO[DATA_WIDTH-1:0];
        flag_next = 1'b0;
      end else if (disp_reg <= 0) begin
        kind_next = STF_FILL_ONE_A_K;
        word_next = STF_FILL_ONE_A[DATA_WIDTH-1:0];
        flag_next = 1'b1;
      end else begin
        kind_next = STF_FILL_ONE_B_K;
        word_next = STF_FILL_ONE_B[DATA_WIDTH-1:0];
        flag_next = 1'b0;
      end
    end
  end

  // Running balance saturates instead of wrapping, so a long run of
  // one-polarity data cannot flip the sign and pick the wrong variant.
  always_comb begin
    disp_next = disp_reg;
    if (frame_ready) begin
      if (word_balance(word_next) > 0 && disp_reg > 8'sd100)
        disp_next = 8'sd127;
      else if (word_balance(word_next) < 0 && disp_reg < -8'sd100)
        disp_next = -8'sd128;
      else
        disp_next = disp_reg + word_balance(word_next);
    end
  end

  // Frame registers, balance, alternating flag and data frame count.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      kind_reg   <= STF_FILL_ZERO_K;
      word_reg   <= '0;
      flag_reg   <= 1'b0;
      disp_reg   <= '0;
      toggle_reg <= 1'b0;
      count_reg  <= 32'h00000000;
    end else begin
      kind_reg <= kind_next;
      word_reg <= word_next;
      flag_reg <= flag_next;
      disp_reg <= disp_next;
      if (take_word && !fifo_out_data[FW-1]) begin
        toggle_reg <= ~toggle_reg;
        count_reg  <= count_reg + 32'h00000001;
      end
    end
  end

  assign frame_kind_out = kind_reg;
  assign frame_word_out = word_reg;
  assign frame_flag_out = flag_reg;

  // ---------------------------------------------------------------
  // Serial clock selection and monitor
  // ---------------------------------------------------------------

  // Nothing here retimes data onto the external clock; the source must
  // already run from the link's clock in that mode.
  stf_clock_monitor u_clock_monitor (
    .pclk                         (pclk),
    .presetn                      (presetn),
    .external_serial_clock_select (ctrl_reg[STF_CTRL_EXT_BIT]),
    .serial_clock_monitor_power   (ctrl_reg[STF_CTRL_MON_BIT]),
    .vco_clock_in                 (vco_clock_in),
    .parallel_clock_in            (parallel_clock_in),
    .serial_clock_external        (serial_clock_external),
    .monitor_out                  (monitor_out),
    .monitor_out_n                (monitor_out_n),
    .monitor_powered              (monitor_powered)
  );

endmodule

`default_nettype wire

/* shared/stf_pkg.sv */
/*
  Shared constants for the serial transmit frame control block: register
  offsets, field positions, reset values, frame kinds and fill patterns.
  Assumes a 32-bit APB register bus and a 20-bit parallel data word.
*/
`default_nettype none

package stf_pkg;

  // ---------------------------------------------------------------
  // Register map (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0] STF_CTRL_OFF   = 8'h00;
  localparam logic [7:0] STF_STATUS_OFF = 8'h04;
  localparam logic [7:0] STF_DISP_OFF   = 8'h08;
  localparam logic [7:0] STF_COUNT_OFF  = 8'h0c;

  // ---------------------------------------------------------------
  // Control register fields and reset value
  // ---------------------------------------------------------------
  localparam int STF_CTRL_FILL_BIT = 0;
  localparam int STF_CTRL_FLAG_BIT = 1;
  localparam int STF_CTRL_EXT_BIT  = 2;
  localparam int STF_CTRL_MON_BIT  = 3;
  localparam int STF_CTRL_WIDTH    = 4;
  localparam logic [3:0] STF_CTRL_RESET = 4'h8;

  // ---------------------------------------------------------------
  // Status register fields
  // ---------------------------------------------------------------
  localparam int STF_STAT_READY_BIT  = 0;
  localparam int STF_STAT_ENABLE_BIT = 1;
  localparam int STF_STAT_FLAG_BIT   = 2;
  localparam int STF_STAT_EXT_BIT    = 3;
  localparam int STF_STAT_LEVEL_LSB  = 8;

  // ---------------------------------------------------------------
  // Word layout and fill patterns
  // ---------------------------------------------------------------
  localparam int STF_DATA_WIDTH = 20;
  localparam int STF_CTRL_BITS  = 18;
  localparam int STF_DISP_WIDTH = 8;
  localparam logic [19:0] STF_CTRL_MASK = 20'h3ffff;
  localparam logic [19:0] STF_FILL_ZERO = 20'h003ff;
  localparam logic [19:0] STF_FILL_ONE_A = 20'h0ffff;
  localparam logic [19:0] STF_FILL_ONE_B = 20'h00f00;

  // Kinds of frame handed to the serializer.
  typedef enum logic [2:0] {
    STF_FILL_ZERO_K,
    STF_FILL_ONE_A_K,
    STF_FILL_ONE_B_K,
    STF_DATA_K,
    STF_CONTROL_K
  } stf_frame_t;

endpackage

`default_nettype wire

/* rtl/stf_fifo.sv */
/*
  Synchronous FIFO of flip-flops with valid/ready on both sides.
  Assumes one clock, active-low asynchronous reset, and DEPTH a power of two.
*/
`timescale 1ns/10ps
`default_nettype none

module stf_fifo #(
  parameter int WIDTH = 21,
  parameter int DEPTH = 16
) (
  // Clock and reset.
  input  wire logic                     pclk,
  input  wire logic                     presetn,
  // Fill side.
  input  wire logic                     in_valid,
  output logic                          in_ready,
  input  wire logic [WIDTH-1:0]         in_data,
  // Drain side.
  input  wire logic                     out_ready,
  output logic                          out_valid,
  output logic      [WIDTH-1:0]         out_data,
  // Fill level.
  output logic      [$clog2(DEPTH):0]   level
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW:0]      wr_ptr_reg;
  logic [AW:0]      rd_ptr_reg;
  logic             push;
  logic             pop;

  // Full when pointers differ only in the wrap bit; empty when equal.
  assign level     = wr_ptr_reg - rd_ptr_reg;
  assign in_ready  = (level != (AW+1)'(DEPTH));
  assign out_valid = (wr_ptr_reg != rd_ptr_reg);
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;
  assign out_data  = mem_reg[rd_ptr_reg[AW-1:0]];

  // Pointers.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
    end else begin
      if (push) wr_ptr_reg <= wr_ptr_reg + 1'b1;
      if (pop)  rd_ptr_reg <= rd_ptr_reg + 1'b1;
    end
  end

  // Storage carries no reset; a word is only read after it was written.
  always_ff @(posedge pclk) begin
    if (push) mem_reg[wr_ptr_reg[AW-1:0]] <= in_data;
  end

endmodule

`default_nettype wire

/* rtl/stf_clock_monitor.sv */
/*
  Serial clock source selection and clock monitor.
  Assumes both candidate clocks arrive as levels sampled on pclk and that
  the analog serializer takes its source from serial_clock_external.
*/
`timescale 1ns/10ps
`default_nettype none

module stf_clock_monitor (
  // Clock and reset.
  input  wire logic pclk,
  input  wire logic presetn,
  // Configuration.
  input  wire logic external_serial_clock_select,
  input  wire logic serial_clock_monitor_power,
  // Candidate clocks, sampled.
  input  wire logic vco_clock_in,
  input  wire logic parallel_clock_in,
  // Outputs.
  output logic      serial_clock_external,
  output logic      monitor_out,
  output logic      monitor_out_n,
  output logic      monitor_powered
);

  logic sel_reg;
  logic src_reg;
  logic src_d_reg;
  logic div_reg;
  logic pwr_reg;
  logic src_now;

  // The monitor follows whichever clock actually drives the serializer.
  assign src_now = sel_reg ? parallel_clock_in : vco_clock_in;

  // Source register, edge detector and divide-by-two toggle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sel_reg   <= 1'b0;
      src_reg   <= 1'b0;
      src_d_reg <= 1'b0;
      div_reg   <= 1'b0;
      pwr_reg   <= 1'b0;
    end else begin
      sel_reg   <= external_serial_clock_select;
      src_reg   <= src_now;
      src_d_reg <= src_reg;
      pwr_reg   <= serial_clock_monitor_power;
      if (!pwr_reg) div_reg <= 1'b0;
      else if (src_reg & ~src_d_reg) div_reg <= ~div_reg;
    end
  end

  // Powered down, both monitor legs rest low and the enable drops.
  assign serial_clock_external = sel_reg;
  assign monitor_powered       = pwr_reg;
  assign monitor_out           = pwr_reg & div_reg;
  assign monitor_out_n         = pwr_reg & ~div_reg;

endmodule

`default_nettype wire

/* tb/stf_tx_frame_sva.sv */
/*
  Port assertions for the transmit frame control block.
  Assumes it is bound to stf_tx_frame, with everything on pclk.
*/
`timescale 1ns/10ps
`default_nettype none

module stf_tx_frame_sva
  import stf_pkg::*;
(
  // Clock, reset and bus.
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic        pready,
  input wire logic [31:0] pwdata,
  // Link and frames.
  input wire logic        link_enable_in,
  input wire logic        ready_for_data_out,
  input wire logic        frame_ready,
  input wire stf_frame_t  frame_kind_out,
  input wire logic [19:0] frame_word_out,
  input wire logic        frame_flag_out,
  // Clocking outputs.
  input wire logic        serial_clock_external,
  input wire logic        monitor_out,
  input wire logic        monitor_out_n,
  input wire logic        monitor_powered
);
  // A shadow of the control word, rebuilt from completed writes.
  logic [3:0] ctrl_q;
  wire        ctrl_wr = psel && penable && pwrite && pready && (paddr == STF_CTRL_OFF);

  // The shadow lets the checker see modes without peeking inside.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= STF_CTRL_RESET;
    end else if (ctrl_wr) begin
      ctrl_q <= pwdata[3:0];
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // A frame edge that was not the first one after reset.
  sequence new_frame_s;
    $past(frame_ready) && $past(presetn);
  endsequence
  // Link enable low for two edges, with a frame taken at the second.
  sequence link_off_s;
    !link_enable_in ##1 !link_enable_in && frame_ready;
  endsequence

  ready_gate_a: assert property (ready_for_data_out |-> $past(link_enable_in))
    else $error("ready without link enable");
  disabled_fill_a: assert property (link_off_s |=>
    frame_kind_out inside {STF_FILL_ZERO_K, STF_FILL_ONE_A_K, STF_FILL_ONE_B_K})
    else $error("non-fill frame while link disabled");
  zero_fill_a: assert property (new_frame_s ##0 frame_kind_out == STF_FILL_ZERO_K
    |-> frame_word_out == STF_FILL_ZERO && !frame_flag_out) else $error("bad zero fill");
  one_a_fill_a: assert property (frame_kind_out == STF_FILL_ONE_A_K
    |-> frame_word_out == STF_FILL_ONE_A && frame_flag_out) else $error("bad fill a");
  one_b_fill_a: assert property (frame_kind_out == STF_FILL_ONE_B_K
    |-> frame_word_out == STF_FILL_ONE_B && !frame_flag_out) else $error("bad fill b");
  frame_hold_a: assert property (!$past(frame_ready) && $past(presetn) |->
    $stable(frame_kind_out) && $stable(frame_word_out) && $stable(frame_flag_out))
    else $error("frame changed while not taken");
  monitor_off_a: assert property (!ctrl_q[3] && !$past(ctrl_q[3]) |->
    !monitor_powered && !monitor_out && !monitor_out_n) else $error("monitor not off");
  monitor_pair_a: assert property (monitor_powered |-> monitor_out != monitor_out_n)
    else $error("monitor outputs not complementary");
  ext_select_a: assert property ($stable(ctrl_q[2]) |-> serial_clock_external == ctrl_q[2])
    else $error("serial clock source differs from select");
endmodule

`default_nettype wire

/* tb/stf_partner.sv */
/*
  Far-side model: receiver startup logic and the user data source.
  Assumes the source runs on pclk, the link's own frame clock.
*/
`timescale 1ns/10ps
`default_nettype none

module stf_partner #(
  parameter int LOCK_CYCLES = 12
) (
  // Clock and reset.
  input  wire logic        pclk,
  input  wire logic        presetn,
  // Bench controls.
  input  wire logic        both_locked,
  input  wire logic        send_enable,
  // Toward the block.
  input  wire logic        ready_for_data_out,
  output logic             link_enable_in,
  output logic             data_available_n,
  output logic [19:0]      data_in,
  output logic             flag_in
);
  logic [7:0]  lock_cnt;
  logic [19:0] word_reg;

  // Words count up; a word is held until taken, so none is lost on a refusal.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lock_cnt <= 8'h00;
      link_enable_in <= 1'b0;
      data_available_n <= 1'b1;
      word_reg <= 20'h00000;
    end else begin
      lock_cnt <= !both_locked ? 8'h00 : (lock_cnt == LOCK_CYCLES ? lock_cnt : lock_cnt + 8'h01);
      link_enable_in <= both_locked && (lock_cnt == LOCK_CYCLES);
      if (!data_available_n && ready_for_data_out) begin
        word_reg <= word_reg + 20'h00001;
      end
      data_available_n <= !(send_enable && ready_for_data_out);
    end
  end

  // Idle data lines show the inverse, so a stale word never looks valid.
  assign data_in = data_available_n ? ~word_reg : word_reg;
  assign flag_in = data_available_n ? ~word_reg[1] : word_reg[1];
endmodule

`default_nettype wire

/* tb/testbench.sv */
/*
  Self-checking bench for stf_tx_frame with the far-side model.
  Assumes the checker is bound here and APB answers with pready.
*/
`timescale 1ns/10ps
`default_nettype none

module testbench
  import stf_pkg::*;
;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [19:0] data_in, frame_word_out, exp_word;
  logic        flag_in, data_available_n, control_available, ready_for_data_out;
  logic        link_enable_in, vco_clock_in, parallel_clock_in, frame_ready;
  logic        frame_flag_out, serial_clock_external, monitor_out, monitor_out_n;
  logic        monitor_powered, both_locked, send_enable, fr_q, mon_q, mode_tb, err;
  stf_frame_t  frame_kind_out;
  logic [21:0] dq[$];
  logic [21:0] e;
  logic [1:0]  pcnt;
  int          n_errors, samples_checked, cycles, rises, r0, n_mode0;

  stf_tx_frame stf_tx_frame_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .data_in, .flag_in, .data_available_n, .control_available,
    .ready_for_data_out, .link_enable_in, .vco_clock_in, .parallel_clock_in, .frame_ready,
    .frame_kind_out, .frame_word_out, .frame_flag_out, .serial_clock_external,
    .monitor_out, .monitor_out_n, .monitor_powered);
  stf_partner stf_partner_i (.pclk, .presetn, .both_locked, .send_enable,
    .ready_for_data_out, .link_enable_in, .data_available_n, .data_in, .flag_in);

  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  // Clock sources, frame logging and a hang guard.
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    fr_q <= frame_ready && presetn;
    mon_q <= monitor_out;
    rises <= rises + ((monitor_out && !mon_q) ? 1 : 0);
    vco_clock_in <= ~vco_clock_in;
    pcnt <= (pcnt == 2'd2) ? 2'd0 : pcnt + 2'd1;
    if (pcnt == 2'd2) parallel_clock_in <= ~parallel_clock_in;
    if (cycles == 20000) begin
      n_errors++;
      print_verdict();
    end
  end
  always @(negedge pclk) begin
    if (fr_q && frame_kind_out === STF_DATA_K) dq.push_back({mode_tb, frame_flag_out, frame_word_out});
  end

  task check(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      $display("unexpected %s expected %h seen %h", what, exp, got);
      n_errors++;
    end
  endtask

  // One APB transfer; the request stands until pready is seen high.
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Data frames come out in order; flags follow the mode they were sent in.
  task pop_data(input int n);
    for (int i = 0; i < n; i++) begin
      while (dq.size() == 0) @(negedge pclk);
      e = dq.pop_front();
      check("data word", {12'h0, exp_word}, {12'h0, e[19:0]});
      if (!e[21]) check("toggled flag", {31'h0, n_mode0[0]}, {31'h0, e[20]});
      else check("extra flag", {31'h0, exp_word[1]}, {31'h0, e[20]});
      if (!e[21]) n_mode0++;
      exp_word = exp_word + 20'h1;
    end
  endtask

  task print_verdict;
    if (n_errors == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, fr_q, mon_q, mode_tb} = '0;
    {control_available, both_locked, vco_clock_in, parallel_clock_in, pcnt} = '0;
    {n_errors, samples_checked, cycles, rises, n_mode0} = '0;
    exp_word = 20'h0;
    frame_ready = 1'b1;
    send_enable = 1'b1;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    repeat (20) @(negedge pclk);
    check("ready while disabled", 32'h0, {31'h0, ready_for_data_out});
    check("kind while disabled", 32'(STF_FILL_ZERO_K), {29'h0, frame_kind_out});
    check("no data frames", 32'h0, dq.size());
    apb(1'b0, STF_CTRL_OFF, 32'h0);
    check("ctrl reset", 32'h8, rd);
    apb(1'b0, 8'h10, 32'h0);
    check("unmapped error", 32'h1, {31'h0, err});
    check("unmapped data", 32'h0, rd);
    // Fill zero keeps balance at zero, so the first one-type fill is a.
    apb(1'b1, STF_CTRL_OFF, 32'h9);
    while (frame_kind_out === STF_FILL_ZERO_K) @(negedge pclk);
    for (int i = 0; i < 4; i++) begin
      check("fill kind", i[0] ? 32'(STF_FILL_ONE_B_K) : 32'(STF_FILL_ONE_A_K), {29'h0, frame_kind_out});
      @(negedge pclk);
    end
    apb(1'b1, STF_CTRL_OFF, 32'h8);
    both_locked <= 1'b1;
    while (link_enable_in !== 1'b1) @(negedge pclk);
    check("ready before retime", 32'h0, {31'h0, ready_for_data_out});
    @(negedge pclk);
    check("ready after retime", 32'h1, {31'h0, ready_for_data_out});
    pop_data(6);
    // Stall the serializer until the buffer refuses.
    @(posedge pclk);
    frame_ready <= 1'b0;
    repeat (40) @(negedge pclk);
    check("ready when full", 32'h0, {31'h0, ready_for_data_out});
    apb(1'b0, STF_STATUS_OFF, 32'h0);
    check("fifo level", 32'h10, {27'h0, rd[12:8]});
    apb(1'b1, STF_CTRL_OFF, 32'ha);
    mode_tb = 1'b1;
    frame_ready <= 1'b1;
    pop_data(24);
    @(posedge pclk);
    both_locked <= 1'b0;
    repeat (4) @(negedge pclk);
    check("fill on link drop", 32'(STF_FILL_ZERO_K), {29'h0, frame_kind_out});
    r0 = rises;
    repeat (48) @(posedge pclk);
    check("vco monitor rate", 32'h1, {31'h0, (rises - r0) inside {[11:13]}});
    apb(1'b1, STF_CTRL_OFF, 32'hc);
    repeat (4) @(posedge pclk);
    check("external clock", 32'h1, {31'h0, serial_clock_external});
    r0 = rises;
    repeat (48) @(posedge pclk);
    check("ext monitor rate", 32'h1, {31'h0, (rises - r0) inside {[3:5]}});
    apb(1'b1, STF_CTRL_OFF, 32'h4);
    repeat (4) @(negedge pclk);
    check("monitor off", 32'h0, {30'h0, monitor_powered, monitor_out});
    print_verdict();
  end
endmodule

bind stf_tx_frame stf_tx_frame_sva stf_tx_frame_sva_i (.pclk, .presetn, .psel, .penable,
  .pwrite, .paddr, .pready, .pwdata, .link_enable_in, .ready_for_data_out, .frame_ready,
  .frame_kind_out, .frame_word_out, .frame_flag_out, .serial_clock_external, .monitor_out,
  .monitor_out_n, .monitor_powered);

`default_nettype wire
